// ===== verilog/didf_dispatcher.sv
// Device idle FIS dispatcher with APB control registers
`timescale 1ns/1ps
module didf_dispatcher
    import didf_pkg::*;
#(
    parameter bit QUEUING = 1'b1, // Command queuing built in
    parameter bit AGGREGATE = 1'b0 // Status aggregation built in
)
(
    input wire logic pclk, // Clock, 250 MHz
    input wire logic presetn, // Async reset, low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic fis_rx_valid, // Received FIS strobe
    input wire didf_fis_t fis_rx, // Received FIS fields
    output logic fis_rx_ready, // Room for a FIS
    input wire didf_queue_t queue_ev, // Queued command conditions
    input wire logic attention_event, // Attention event pulse
    input wire logic proto_done, // Downstream protocol finished
    output logic dispatch_valid, // Dispatch pulse
    output didf_target_t dispatch_target, // Chosen destination
    output logic [7:0] dispatch_command, // Command for protocol select
    output logic sdb_valid, // Device-bits FIS offered
    output logic [31:0] sdb_dword0, // Device-bits FIS dword 0
    input wire logic sdb_ready // Transport takes device-bits FIS
);

    function automatic logic is_reg_fis(input didf_fis_t f);
        is_reg_fis = (f.fis_type == FIS_REG_H2D);
    endfunction

    didf_state_t state_q;
    didf_fis_t fis_q;
    logic fis_pend_q;
    logic flag_q;
    logic attn_q;
    logic notify_en_q;
    logic [15:0] devstat_q;
    logic [31:0] last_sdb_q;
    logic sdb_load;
    logic sdb_sent;
    logic apb_wr;
    logic apb_setup;
    logic addr_ok;
    logic take_fis;
    logic go_notify;
    didf_target_t idle_tgt;

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data prepared in setup
    assign apb_setup = psel & ~penable;
    assign apb_wr = psel & penable & pready & pwrite;
    assign addr_ok = (paddr == REG_CTRL) || (paddr == REG_DEVSTAT) ||
                     (paddr == REG_STATUS) || (paddr == REG_LAST_SDB);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= apb_setup;
            pslverr <= apb_setup & ~addr_ok;
            if (apb_setup && !pwrite)
            begin
                unique case (paddr)
                    REG_CTRL: prdata <= {31'h0000_0000, notify_en_q};
                    REG_DEVSTAT: prdata <= {16'h0000, devstat_q};
                    REG_STATUS: prdata <= {25'h000_0000, state_q, 1'b0, fis_pend_q,
                                           attn_q, flag_q};
                    REG_LAST_SDB: prdata <= last_sdb_q;
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Software writable control; feature is off after reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            notify_en_q <= CTRL_RESET[CTRL_NOTIFY_EN_BIT];
            devstat_q <= DEVSTAT_RESET;
        end
        else if (apb_wr && paddr == REG_CTRL)
        begin
            notify_en_q <= pwdata[CTRL_NOTIFY_EN_BIT];
        end
        else if (apb_wr && paddr == REG_DEVSTAT)
        begin
            devstat_q <= pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One-deep FIS holder so a FIS arriving outside idle waits
    assign take_fis = (state_q == ST_IDLE) && fis_pend_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fis_pend_q <= 1'b0;
            fis_q <= '0;
            fis_rx_ready <= 1'b1;
        end
        else
        begin
            if (fis_rx_valid && fis_rx_ready)
            begin
                fis_pend_q <= 1'b1;
                fis_q <= fis_rx;
                fis_rx_ready <= 1'b0;
            end
            else if (take_fis)
            begin
                fis_pend_q <= 1'b0;
                fis_rx_ready <= 1'b1;
            end
        end
    end

    // Attention is sticky; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            attn_q <= 1'b0;
        end
        else if (attention_event)
        begin
            attn_q <= 1'b1;
        end
        else if (sdb_sent)
        begin
            attn_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Idle branch choice; a received FIS always comes first
    always_comb
    begin
        idle_tgt = TGT_NONE;
        if (QUEUING && !fis_pend_q)
        begin
            if (queue_ev.cmd_failed)
            begin
                idle_tgt = TGT_QUEUED_ERROR;
            end
            else if (queue_ev.ready_to_complete)
            begin
                idle_tgt = TGT_SET_SERVICE;
            end
            else if (!queue_ev.error)
            begin
                // Aggregating parts may run data first; others must report status first
                if (queue_ev.cmds_completed && !(AGGREGATE &&
                    (queue_ev.write_ready || queue_ev.read_ready)))
                begin
                    idle_tgt = TGT_SEND_STATUS;
                end
                else if (queue_ev.write_ready)
                begin
                    idle_tgt = TGT_WRITE_SETUP;
                end
                else if (queue_ev.read_ready)
                begin
                    idle_tgt = TGT_READ_SETUP;
                end
            end
        end
    end

    assign go_notify = notify_en_q && attn_q && !flag_q && !fis_pend_q;

    ////////////////////////////////////////////////////////////////////////
    // Dispatcher state machine
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_IDLE;
            dispatch_valid <= 1'b0;
            dispatch_target <= TGT_NONE;
            dispatch_command <= 8'h00;
        end
        else
        begin
            dispatch_valid <= 1'b0;
            unique case (state_q)
                ST_IDLE:
                begin
                    if (fis_pend_q)
                    begin
                        state_q <= ST_FIS_CHECK;
                    end
                    else if (idle_tgt != TGT_NONE)
                    begin
                        state_q <= ST_HANDOFF;
                        dispatch_valid <= 1'b1;
                        dispatch_target <= idle_tgt;
                    end
                    else if (go_notify)
                    begin
                        state_q <= ST_NOTIFY;
                    end
                end
                ST_FIS_CHECK:
                begin
                    if (is_reg_fis(fis_q) && fis_q.c_bit)
                    begin
                        state_q <= ST_CMD_CHECK;
                        dispatch_command <= fis_q.command; // Taken before the holder refills
                    end
                    else if (is_reg_fis(fis_q) && fis_q.soft_reset_bit)
                    begin
                        state_q <= ST_HANDOFF;
                        dispatch_valid <= 1'b1;
                        dispatch_target <= TGT_SOFT_RESET;
                    end
                    else
                    begin
                        // Soft reset clear, DMA setup, or unknown type: drop
                        state_q <= ST_IDLE;
                    end
                end
                ST_CMD_CHECK:
                begin
                    state_q <= ST_HANDOFF;
                    dispatch_valid <= 1'b1;
                    dispatch_target <= TGT_COMMAND;
                end
                ST_NOTIFY:
                begin
                    if (sdb_sent)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_HANDOFF:
                begin
                    // Protocol bodies live outside; wait for them to finish
                    if (proto_done)
                    begin
                        state_q <= ST_IDLE;
                        dispatch_target <= TGT_NONE;
                    end
                end
            endcase
        end
    end

    // Outstanding flag: set when the FIS goes out, cleared on command check
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_q <= 1'b0;
        end
        else if (sdb_sent)
        begin
            flag_q <= 1'b1;
        end
        else if (state_q == ST_CMD_CHECK)
        begin
            flag_q <= 1'b0;
        end
    end

    // Keep a copy of the last notification for software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_sdb_q <= 32'h0000_0000;
        end
        else if (sdb_sent)
        begin
            last_sdb_q <= sdb_dword0;
        end
    end

    assign sdb_load = (state_q == ST_NOTIFY);

    ////////////////////////////////////////////////////////////////////////
    // Device-bits FIS builder
    didf_sdb_builder u_sdb (
        .pclk(pclk),
        .presetn(presetn),
        .load(sdb_load),
        .status_in(devstat_q[7:0]),
        .error_in(devstat_q[15:8]),
        .tx_ready(sdb_ready),
        .tx_valid(sdb_valid),
        .tx_dword0(sdb_dword0),
        .sent(sdb_sent)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_fis_first;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_IDLE && fis_pend_q) |=> (state_q == ST_FIS_CHECK);
    endproperty
    a_fis_first: assert property (p_fis_first) else $error("FIS not checked");

    property p_cmd_path;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_FIS_CHECK && is_reg_fis(fis_q) && fis_q.c_bit) |=> (state_q == ST_CMD_CHECK)
        ##1 (dispatch_valid && dispatch_target == TGT_COMMAND);
    endproperty
    a_cmd_path: assert property (p_cmd_path) else $error("Command path wrong");

    property p_soft_reset_bit;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_FIS_CHECK && is_reg_fis(fis_q) && !fis_q.c_bit && fis_q.soft_reset_bit)
        |=> (dispatch_valid && dispatch_target == TGT_SOFT_RESET);
    endproperty
    a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("Soft reset missed");

    property p_drop;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_FIS_CHECK && !is_reg_fis(fis_q)) |=> (state_q == ST_IDLE && !dispatch_valid);
    endproperty
    a_drop: assert property (p_drop) else $error("FIS not dropped");

    property p_clear_flag;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_CMD_CHECK) |=> !flag_q;
    endproperty
    a_clear_flag: assert property (p_clear_flag) else $error("Flag not cleared");

    property p_notify_gate;
        @(posedge pclk) disable iff (!presetn)
        (state_q != ST_NOTIFY) ##1 (state_q == ST_NOTIFY) |->
        $past(notify_en_q) && $past(attn_q) && !$past(flag_q);
    endproperty
    a_notify_gate: assert property (p_notify_gate) else $error("Bad notify entry");

    property p_n_bit;
        @(posedge pclk) disable iff (!presetn)
        $rose(sdb_valid) |-> sdb_dword0[SDB_N_BIT] && sdb_dword0[SDB_I_BIT] &&
        sdb_dword0[7:0] == FIS_SET_DEV_BITS && sdb_dword0[11:8] == 4'h0 && $past(notify_en_q);
    endproperty
    a_n_bit: assert property (p_n_bit) else $error("Bad device-bits FIS");

    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        sdb_sent |=> flag_q && state_q == ST_IDLE;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("Flag not set");

    property p_status_first;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_IDLE && !fis_pend_q && !AGGREGATE && QUEUING && queue_ev.cmds_completed &&
         !queue_ev.error && !queue_ev.cmd_failed && !queue_ev.ready_to_complete)
        |=> (dispatch_target == TGT_SEND_STATUS);
    endproperty
    a_status_first: assert property (p_status_first) else $error("Status not first");

    property p_no_queue;
        @(posedge pclk) disable iff (!presetn)
        !QUEUING |-> !(dispatch_target inside {TGT_SET_SERVICE, TGT_WRITE_SETUP,
                       TGT_READ_SETUP, TGT_SEND_STATUS, TGT_QUEUED_ERROR});
    endproperty
    a_no_queue: assert property (p_no_queue) else $error("Queue branch taken");

    c_notify: cover property (@(posedge pclk) disable iff (!presetn) sdb_sent);
    c_command: cover property (@(posedge pclk) disable iff (!presetn)
        dispatch_valid && dispatch_target == TGT_COMMAND);
    c_write: cover property (@(posedge pclk) disable iff (!presetn)
        dispatch_valid && dispatch_target == TGT_WRITE_SETUP);

endmodule // didf_dispatcher

// ===== verilog/didf_pkg.sv
// Constants and types of the device idle FIS dispatcher
package didf_pkg;

    // FIS type codes
    localparam logic [7:0] FIS_REG_H2D = 8'h27;
    localparam logic [7:0] FIS_DMA_SETUP = 8'h41;
    localparam logic [7:0] FIS_SET_DEV_BITS = 8'ha1;

    // Device-bits dword 0 layout
    localparam int SDB_TYPE_LSB = 0;
    localparam int SDB_I_BIT = 14;
    localparam int SDB_N_BIT = 15;
    localparam int SDB_STATUS_LSB = 16;
    localparam int SDB_ERROR_LSB = 24;
    localparam logic [7:0] SDB_STATUS_MASK = 8'h77; // Bits 3 and 7 reserved

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DEVSTAT = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_LAST_SDB = 8'h0c;

    // Field positions and reset values
    localparam int CTRL_NOTIFY_EN_BIT = 0;
    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_ATTN_BIT = 1;
    localparam int STAT_FIS_PEND_BIT = 2;
    localparam int STAT_STATE_LSB = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] DEVSTAT_RESET = 16'h0050;

    typedef enum logic [2:0] {
        ST_IDLE, ST_FIS_CHECK, ST_CMD_CHECK, ST_NOTIFY, ST_HANDOFF
    } didf_state_t;

    typedef enum logic [2:0] {
        TGT_NONE, TGT_SOFT_RESET, TGT_COMMAND, TGT_SET_SERVICE,
        TGT_WRITE_SETUP, TGT_READ_SETUP, TGT_SEND_STATUS, TGT_QUEUED_ERROR
    } didf_target_t;

    typedef struct packed {
        logic [7:0] fis_type;
        logic c_bit;
        logic soft_reset_bit;
        logic [7:0] command;
    } didf_fis_t;

    typedef struct packed {
        logic ready_to_complete;
        logic write_ready;
        logic read_ready;
        logic cmds_completed;
        logic cmd_failed;
        logic error;
    } didf_queue_t;

endpackage

// ===== verilog/didf_sdb_builder.sv
// Device-bits FIS builder with transmit handshake
`timescale 1ns/1ps
module didf_sdb_builder
    import didf_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, low
    input wire logic load, // Build and offer a notification FIS
    input wire logic [7:0] status_in, // Current status byte
    input wire logic [7:0] error_in, // Current error byte
    input wire logic tx_ready, // Transport takes the FIS
    output logic tx_valid, // FIS offered
    output logic [31:0] tx_dword0, // FIS dword 0
    output logic sent // FIS taken this cycle
);

    ////////////////////////////////////////////////////////////////////////
    // Offer held until taken; reserved fields left zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_valid <= 1'b0;
            tx_dword0 <= 32'h0000_0000;
        end
        else if (load && !tx_valid)
        begin
            tx_valid <= 1'b1;
            tx_dword0 <= 32'h0000_0000;
            tx_dword0[SDB_TYPE_LSB +: 8] <= FIS_SET_DEV_BITS;
            tx_dword0[SDB_I_BIT] <= 1'b1;
            tx_dword0[SDB_N_BIT] <= 1'b1;
            tx_dword0[SDB_STATUS_LSB +: 8] <= status_in & SDB_STATUS_MASK;
            tx_dword0[SDB_ERROR_LSB +: 8] <= error_in;
        end
        else if (tx_valid && tx_ready)
        begin
            tx_valid <= 1'b0;
        end
    end

    // Acceptance strobe back to the dispatcher
    assign sent = tx_valid & tx_ready;

endmodule // didf_sdb_builder

// ===== verif/didf_host_model.sv
// Host-side partner: offers received FIS and takes device-bits FIS
`timescale 1ns/1ps
module didf_host_model
    import didf_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, low
    input wire logic send, // Offer req from next cycle
    input wire didf_fis_t req, // FIS to offer
    input wire logic [3:0] stall, // Wait before taking device-bits
    output logic fis_rx_valid, // FIS offered
    output didf_fis_t fis_rx, // FIS fields
    input wire logic fis_rx_ready, // Device has room
    input wire logic sdb_valid, // Device-bits offered
    input wire logic [31:0] sdb_dword0, // Device-bits dword 0
    output logic sdb_ready, // Device-bits taken
    output logic [31:0] sdb_last, // Last dword 0 taken
    output int sdb_count // Device-bits taken so far
);
    logic [3:0] wait_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Offer held until taken; fields scrambled after, so stale data never looks valid
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fis_rx_valid <= 1'b0;
            fis_rx <= '0;
        end
        else if (send)
        begin
            fis_rx_valid <= 1'b1;
            fis_rx <= req;
        end
        else if (fis_rx_valid && fis_rx_ready)
        begin
            fis_rx_valid <= 1'b0;
            fis_rx <= ~fis_rx;
        end
    end
    // Slow or prompt taker of device-bits FIS
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_q <= 4'h0;
            sdb_ready <= 1'b0;
            sdb_last <= 32'h0;
            sdb_count <= 0;
        end
        else if (sdb_valid && sdb_ready)
        begin
            sdb_ready <= 1'b0;
            wait_q <= 4'h0;
            sdb_last <= sdb_dword0;
            sdb_count <= sdb_count + 1;
        end
        else if (sdb_valid && wait_q >= stall)
            sdb_ready <= 1'b1;
        else if (sdb_valid)
            wait_q <= wait_q + 4'h1;
    end
endmodule // didf_host_model

// ===== verif/tb.sv
// Self-checking testbench of the idle FIS dispatcher
`timescale 1ns/1ps
module tb;
    import didf_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, sdb_dword0, sdb_last;
    logic pready, pslverr, fis_rx_valid, fis_rx_ready, dispatch_valid, sdb_valid, sdb_ready;
    logic attention_event = 1'b0, proto_done = 1'b0, send = 1'b0;
    logic [3:0] stall = 4'h0;
    logic [7:0] dispatch_command;
    didf_fis_t fis_rx, req = '0;
    didf_queue_t queue_ev = '0;
    didf_target_t dispatch_target;
    int sdb_count, miscompares = 0, checked = 0, cycles = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // 250 MHz clock
    always #2 pclk = ~pclk;
    didf_dispatcher #(.QUEUING(1'b1), .AGGREGATE(1'b0)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fis_rx_valid(fis_rx_valid),
        .fis_rx(fis_rx), .fis_rx_ready(fis_rx_ready), .queue_ev(queue_ev),
        .attention_event(attention_event), .proto_done(proto_done),
        .dispatch_valid(dispatch_valid), .dispatch_target(dispatch_target),
        .dispatch_command(dispatch_command), .sdb_valid(sdb_valid),
        .sdb_dword0(sdb_dword0), .sdb_ready(sdb_ready));
    didf_host_model u_host (.pclk(pclk), .presetn(presetn), .send(send), .req(req),
        .stall(stall), .fis_rx_valid(fis_rx_valid), .fis_rx(fis_rx),
        .fis_rx_ready(fis_rx_ready), .sdb_valid(sdb_valid), .sdb_dword0(sdb_dword0),
        .sdb_ready(sdb_ready), .sdb_last(sdb_last), .sdb_count(sdb_count));
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and counts
    task automatic wrap_up();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // APB transfer; holds the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic send_fis(input logic [7:0] t, input logic c, input logic s);
        @(posedge pclk);
        send <= 1'b1;
        req <= '{fis_type: t, c_bit: c, soft_reset_bit: s, command: 8'hc3};
        @(posedge pclk);
        send <= 1'b0;
    endtask
    // Bounded watch for one dispatch, then releases the handoff
    task automatic expect_dispatch(input didf_target_t tgt);
        logic seen;
        seen = 1'b0;
        for (int n = 0; n < 12 && !seen; n++)
        begin
            @(negedge pclk);
            if (dispatch_valid === 1'b1)
            begin
                seen = 1'b1;
                chk("target", {29'h0, tgt}, {29'h0, dispatch_target});
                if (tgt == TGT_COMMAND)
                    chk("command", 32'hc3, {24'h0, dispatch_command});
            end
        end
        chk("dispatched", {31'h0, tgt != TGT_NONE}, {31'h0, seen});
        @(posedge pclk);
        queue_ev <= '0;
        proto_done <= seen;
        @(posedge pclk);
        proto_done <= 1'b0;
    endtask
    task automatic pulse_attention();
        @(posedge pclk);
        attention_event <= 1'b1;
        @(posedge pclk);
        attention_event <= 1'b0;
    endtask
    task automatic wait_sdb(input int n);
        for (int i = 0; i < 40 && sdb_count != n; i++)
            @(negedge pclk);
        chk("sdb count", n, sdb_count);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        chk("rx ready", 32'h1, {31'h0, fis_rx_ready});
        apb(1'b0, REG_CTRL, 32'h0, r, e);
        chk("ctrl", CTRL_RESET, r);
        apb(1'b0, REG_DEVSTAT, 32'h0, r, e);
        chk("devstat", {16'h0, DEVSTAT_RESET}, r);
        apb(1'b0, REG_STATUS, 32'h0, r, e);
        chk("status", 32'h0, r);
        apb(1'b0, 8'h10, 32'h0, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        $display("test reset done");
    endtask
    task automatic t_fis();
        send_fis(FIS_REG_H2D, 1'b1, 1'b0);
        expect_dispatch(TGT_COMMAND);
        send_fis(FIS_REG_H2D, 1'b0, 1'b1);
        expect_dispatch(TGT_SOFT_RESET);
        send_fis(FIS_REG_H2D, 1'b0, 1'b0);
        expect_dispatch(TGT_NONE);
        send_fis(FIS_DMA_SETUP, 1'b1, 1'b0);
        expect_dispatch(TGT_NONE);
        send_fis(8'h34, 1'b1, 1'b1);
        expect_dispatch(TGT_NONE);
        $display("test fis done");
    endtask
    task automatic q_case(input logic [5:0] v, input didf_target_t tgt);
        @(posedge pclk);
        queue_ev <= v;
        expect_dispatch(tgt);
    endtask
    task automatic t_queue();
        q_case(6'b000010, TGT_QUEUED_ERROR);
        q_case(6'b100000, TGT_SET_SERVICE);
        q_case(6'b011100, TGT_SEND_STATUS);
        q_case(6'b010000, TGT_WRITE_SETUP);
        q_case(6'b001000, TGT_READ_SETUP);
        q_case(6'b010001, TGT_NONE);
        $display("test queue done");
    endtask
    task automatic t_notify();
        logic [31:0] r;
        logic e;
        apb(1'b1, REG_DEVSTAT, 32'h0000_5aff, r, e);
        pulse_attention();
        repeat (20) @(posedge pclk);
        chk("sdb while off", 32'h0, sdb_count);
        stall <= 4'h5;
        apb(1'b1, REG_CTRL, 32'h1, r, e);
        pulse_attention();
        wait_sdb(1);
        chk("sdb dword", {8'h5a, 8'hff & SDB_STATUS_MASK, 8'hc0, FIS_SET_DEV_BITS}, sdb_last);
        apb(1'b0, REG_STATUS, 32'h0, r, e);
        chk("flag", 32'h1, {31'h0, r[STAT_FLAG_BIT]});
        pulse_attention();
        repeat (20) @(posedge pclk);
        chk("sdb held back", 32'h1, sdb_count);
        send_fis(FIS_REG_H2D, 1'b1, 1'b0);
        expect_dispatch(TGT_COMMAND);
        wait_sdb(2);
        $display("test notify done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Hang guard well above the expected run length
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            wrap_up();
        end
    end
    // Main sequence
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_fis();
        t_queue();
        t_notify();
        wrap_up();
    end
endmodule // tb
